// ===== hw/asc_ctrl.sv
// Purpose: select, power-down, mux and approximation control of a serial converter
// Assumes: comparator and trial code live on the core clock; shift clock is the link clock
// Notes: core clock 20 MHz; falling link edges reach the core as a gray count, input bits are read straight from the link history
`include "asc_regs.svh"
`default_nettype none

module asc_ctrl #(
    parameter int CS_DEB_CYCLES = `ASC_CS_DEB_CYC,
    parameter int IDLE_CYCLES = `ASC_IDLE_CYC,
    parameter int STEP_CYCLES = `ASC_STEP_CYC
) (
    // Core clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Serial link
    input wire logic i_link_clock,
    input wire asc_pkg::asc_ser_in_type i_ser,
    output asc_pkg::asc_ser_out_type o_ser,
    // Analog array side
    input wire logic i_cmp_above,
    output logic [11:0] o_trial,
    output logic o_sample,
    output asc_pkg::asc_mux_type o_mux,
    output logic o_power_down
);
    import asc_pkg::*;

    // =================================================================
    // Elaboration checks
    if (CS_DEB_CYCLES < 1 || CS_DEB_CYCLES > 255) begin : g_chk_deb
        $error("CS_DEB_CYCLES out of range");
    end
    if (IDLE_CYCLES < 1 || IDLE_CYCLES > 255) begin : g_chk_idle
        $error("IDLE_CYCLES out of range");
    end
    if (STEP_CYCLES < 1 || STEP_CYCLES > 255) begin : g_chk_step
        $error("STEP_CYCLES out of range");
    end

    // Terminal counts
    localparam logic [7:0] DEB_LAST = 8'(CS_DEB_CYCLES - 1);
    localparam logic [7:0] IDLE_LAST = 8'(IDLE_CYCLES - 1);
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

    asc_core_type q_r;   // Core state
    asc_core_type q_nxt; // Next core state
    logic [2:0] link_gray; // Count from the link
    logic [7:0] link_hist; // Input bits from the link
    logic [3:0] sync_out;  // Select and count, synchronised
    logic cs_s;            // Select level, synchronised
    logic new_edge;        // A falling edge arrived
    logic [4:0] idx_inc;   // Edge index after this edge
    logic last_edge;       // Final edge of the cycle
    logic [11:0] decided;  // Trial with this bit decided

    // =================================================================
    // Link-side logic
    asc_link u_link (
        .i_link_clock(i_link_clock),
        .i_srst(i_srst),
        .i_data_in(i_ser.data_in),
        .o_gray(link_gray),
        .o_hist(link_hist)
    );

    // Select pin and gray count into the core domain
    asc_sync u_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_async({~i_ser.cs_n, link_gray}), // Select as active high: reset stage reads idle
        .o_sync(sync_out)
    );

    // =================================================================
    // Mux decode of an address
    function automatic asc_mux_type mux_decode(input logic [3:0] code);
        asc_mux_type m;
        m = '0;
        if (code <= `ASC_ADDR_EXT_LAST || code == 4'hF) begin
            m.ext_en = 1'b1;
            m.ext_ch = code;
        end else if (code != `ASC_ADDR_PWDN) begin
            m.test_en = 1'b1;
            m.test_sel = 2'(code - `ASC_ADDR_TEST_MID);
        end
        return m;
    endfunction : mux_decode

    // Result bit shown after k falling edges
    function automatic logic out_bit(input logic [11:0] res, input logic [1:0] len,
                                     input logic lsbf, input logic [4:0] k);
        logic [15:0] word;
        logic [4:0] bits;
        logic [4:0] pos;
        word = {res, 4'h0}; // Pad bits follow the result
        bits = (len == `ASC_LEN_8) ? `ASC_EDGE_CTRL :
               (len == `ASC_LEN_16) ? `ASC_EDGE_16 : `ASC_EDGE_12;
        pos = lsbf ? 5'(`ASC_EDGE_16 - bits + k) : 5'(5'h0F - k);
        if (k >= bits) begin
            return 1'b0;
        end
        return word[pos[3:0]];
    endfunction : out_bit

    // Start of an I/O cycle: reset state of the serial side
    function automatic asc_core_type start_cycle(input asc_core_type s);
        asc_core_type t;
        t = s;
        t.st = ST_FRAME;
        t.idx = '0;
        t.out_len = s.len_sel;
        t.out_lsbf = s.lsbf_next;
        t.eoc = 1'b1;
        t.sampling = 1'b0;
        t.mk_pend = 1'b0;
        t.dout = out_bit(s.res_buf, s.len_sel, s.lsbf_next, 5'h00);
        return t;
    endfunction : start_cycle

    // =================================================================
    // Edge detection and decision helpers
    always_comb begin
        cs_s = ~sync_out[3]; // Back to the pin's active-low sense
        new_edge = (sync_out[2:0] != q_r.prev_gray);
        idx_inc = q_r.idx + 5'h01;
        last_edge = (idx_inc == `ASC_EDGE_CTRL && link_hist[`ASC_FLD_LEN] == `ASC_LEN_8) ||
                    (idx_inc == `ASC_EDGE_12 && q_r.len_sel != `ASC_LEN_16) ||
                    (idx_inc == `ASC_EDGE_16);
        decided = q_r.trial;
        if (i_cmp_above) begin
            decided[q_r.bitpos] = 1'b0;
        end
    end

    // =================================================================
    // Next core state
    always_comb begin
        q_nxt = q_r;
        q_nxt.prev_gray = sync_out[2:0];

        // Select debounce
        if (cs_s == q_r.cs_deb) begin
            q_nxt.deb_cnt = '0;
        end else if (q_r.deb_cnt == DEB_LAST) begin
            q_nxt.cs_deb = cs_s;
            q_nxt.deb_cnt = '0;
        end else begin
            q_nxt.deb_cnt = q_r.deb_cnt + 8'h01;
        end

        unique case (q_r.st)
            // Deselected: shift edges ignored
            ST_OFF: begin
                if (!q_r.cs_deb) begin
                    q_nxt.st = ST_GUARD;
                    q_nxt.gcnt = '0;
                end
            end
            // Reselected: shift clock held low a while
            ST_GUARD: begin
                if (q_r.gcnt == IDLE_LAST) begin
                    q_nxt = start_cycle(q_nxt);
                end else begin
                    q_nxt.gcnt = q_r.gcnt + 8'h01;
                end
            end
            // Transfer cycle; runs on in power-down
            ST_FRAME: begin
                if (new_edge) begin
                    q_nxt.idx = idx_inc;
                    q_nxt.dout = out_bit(q_r.res_buf, q_r.out_len, q_r.out_lsbf, idx_inc);
                    if (idx_inc == `ASC_EDGE_ADDR) begin
                        q_nxt.addr = link_hist[`ASC_FLD_ADDR];
                        q_nxt.mux = '0;
                        if (link_hist[`ASC_FLD_ADDR] == `ASC_ADDR_PWDN) begin
                            q_nxt.pd = 1'b1;
                        end else begin
                            q_nxt.sampling = 1'b1;
                            q_nxt.mk_pend = 1'b1;
                        end
                    end
                    if (idx_inc == `ASC_EDGE_CTRL) begin
                        // Control bits of the input byte
                        q_nxt.len_sel = link_hist[`ASC_FLD_LEN];
                        q_nxt.bip = link_hist[`ASC_FLD_BIP];
                        q_nxt.lsbf_next = link_hist[`ASC_FLD_LSBF];
                    end
                    if (last_edge) begin
                        q_nxt.sampling = 1'b0;
                        q_nxt.mux = '0;
                        q_nxt.mk_pend = 1'b0;
                        if (q_r.addr == `ASC_ADDR_PWDN) begin
                            q_nxt = start_cycle(q_nxt);
                        end else begin
                            q_nxt.pd = 1'b0;
                            q_nxt.st = ST_CONV;
                            q_nxt.eoc = 1'b0;
                            q_nxt.dout = 1'b0;
                            q_nxt.trial = `ASC_MSB_TRIAL;
                            q_nxt.bitpos = `ASC_MSB_POS;
                            q_nxt.gcnt = '0;
                        end
                    end
                end else if (q_r.mk_pend) begin
                    q_nxt.mux = mux_decode(q_r.addr);
                    q_nxt.mk_pend = 1'b0;
                end
            end
            // Successive approximation, one bit per step
            ST_CONV: begin
                if (q_r.gcnt == STEP_LAST) begin
                    q_nxt.gcnt = '0;
                    q_nxt.trial = decided;
                    if (q_r.bitpos == 4'h0) begin
                        // Latch result; saturates by the comparator alone
                        q_nxt.res_buf = {decided[11] ^ q_r.bip, decided[10:0]};
                        q_nxt = start_cycle(q_nxt);
                    end else begin
                        q_nxt.bitpos = q_r.bitpos - 4'h1;
                        q_nxt.trial[q_r.bitpos - 4'h1] = 1'b1;
                    end
                end else begin
                    q_nxt.gcnt = q_r.gcnt + 8'h01;
                end
            end
        endcase

        // Debounced deselect aborts whatever runs; result kept
        if (q_r.cs_deb) begin
            q_nxt.st = ST_OFF;
            q_nxt.sampling = 1'b0;
            q_nxt.mk_pend = 1'b0;
            q_nxt.mux = '0;
            q_nxt.eoc = 1'b1;
        end

        // Synchronous reset: deselected and powered down
        if (i_srst) begin
            q_nxt = '0;
            q_nxt.st = ST_OFF;
            q_nxt.cs_deb = 1'b1;
            q_nxt.pd = 1'b1;
            q_nxt.eoc = 1'b1;
        end
    end

    // =================================================================
    // State register
    always_ff @(posedge i_clock) begin
        q_r <= q_nxt;
    end

    // =================================================================
    // Outputs
    assign o_ser.data_out = q_r.dout;
    assign o_ser.data_oe_n = i_ser.cs_n | q_r.cs_deb;
    assign o_ser.eoc = q_r.eoc;
    assign o_trial = q_r.trial;
    assign o_sample = q_r.sampling;
    assign o_mux = q_r.mux;
    assign o_power_down = q_r.pd;

endmodule : asc_ctrl

`default_nettype wire

// ===== hw/asc_regs.svh
// Purpose: timing counts, address codes and field positions of the converter control
// Assumes: included by bare name wherever a count or a code is needed
// Notes: definitions only; times in ns, debounce and step counts derived from the core clock period, idle count fixed
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// =====================================================================
// Timing
`define ASC_CLK_NS 50
`define ASC_CS_DEB_NS 1425
`define ASC_CS_DEB_CYC ((`ASC_CS_DEB_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_IDLE_CYC 4
`define ASC_CONV_NS 10000
`define ASC_RES_BITS 12
`define ASC_STEP_CYC (`ASC_CONV_NS / (`ASC_CLK_NS * `ASC_RES_BITS))

// =====================================================================
// Address codes
`define ASC_ADDR_EXT_LAST 4'hA
`define ASC_ADDR_TEST_MID 4'hB
`define ASC_ADDR_TEST_LOW 4'hC
`define ASC_ADDR_TEST_HIGH 4'hD
`define ASC_ADDR_PWDN 4'hE

// =====================================================================
// Input byte fields and length codes
`define ASC_FLD_ADDR 3:0
`define ASC_FLD_LEN 3:2
`define ASC_FLD_LSBF 1
`define ASC_FLD_BIP 0
`define ASC_LEN_8 2'h1
`define ASC_LEN_16 2'h3

// =====================================================================
// Falling-edge positions within a cycle; first trial code and its bit position
`define ASC_EDGE_ADDR 5'h04
`define ASC_EDGE_CTRL 5'h08
`define ASC_EDGE_12 5'h0C
`define ASC_EDGE_16 5'h10
`define ASC_MSB_TRIAL 12'h800
`define ASC_MSB_POS 4'hB

`endif

// ===== hw/asc_pkg.sv
// Purpose: types shared by the converter control modules
// Assumes: compiled before every other design file
// Notes: carriers for pins, mux control and module state
`default_nettype none

package asc_pkg;

    // =================================================================
    // Control states
    typedef enum logic [1:0] {ST_OFF, ST_GUARD, ST_FRAME, ST_CONV} asc_state_type;

    // Serial pins in and out
    typedef struct packed {
        logic cs_n;     // Unit select, active low
        logic data_in;  // Address and control bits
    } asc_ser_in_type;

    typedef struct packed {
        logic data_out;  // Result bit
        logic data_oe_n; // Low while driving data_out
        logic eoc;       // Conversion done
    } asc_ser_out_type;

    // Input multiplexer control
    typedef struct packed {
        logic ext_en;         // External channel connected
        logic [3:0] ext_ch;   // External channel code
        logic test_en;        // Self-test voltage connected
        logic [1:0] test_sel; // 0 mid, 1 low, 2 high reference
    } asc_mux_type;

    // Two-stage synchroniser state
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } asc_sync_type;

    // Link-side state
    typedef struct packed {
        logic r1;         // Reset sync, first stage
        logic r2;         // Reset sync, second stage
        logic [2:0] bin;  // Falling-edge count
        logic [2:0] gray; // Same count, gray coded
        logic [7:0] hist; // Last eight input bits
    } asc_link_type;

    // Core control state
    typedef struct packed {
        asc_state_type st;
        logic cs_deb;        // Debounced select level
        logic [7:0] deb_cnt; // Debounce counter
        logic [7:0] gcnt;    // Guard or step counter
        logic [2:0] prev_gray;
        logic [4:0] idx;     // Falling edges this cycle
        logic [3:0] addr;    // Address of this cycle
        logic mk_pend;       // Connect after break
        logic pd;            // Powered down
        logic sampling;      // Sample switch closed
        logic [1:0] len_sel; // Programmed length code
        logic bip;           // Bipolar for this conversion
        logic lsbf_next;     // Order for next cycle
        logic out_lsbf;      // Order of this cycle
        logic [1:0] out_len; // Length of this cycle
        logic [11:0] res_buf;
        logic [11:0] trial;
        logic [3:0] bitpos;
        logic dout;
        logic eoc;
        asc_mux_type mux;
    } asc_core_type;

endpackage : asc_pkg

`default_nettype wire

// ===== hw/asc_sync.sv
// Purpose: two-flop synchroniser for the select pin and the edge count
// Assumes: inputs change no faster than the core clock can follow
// Notes: the first stage feeds only the second
`default_nettype none

module asc_sync (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Async inputs
    input wire logic [3:0] i_async,
    // Synchronised outputs
    output logic [3:0] o_sync
);
    import asc_pkg::*;

    asc_sync_type q_r;   // Stages
    asc_sync_type q_nxt; // Next stages

    // =================================================================
    // Next value
    always_comb begin
        q_nxt.s1 = i_async;
        q_nxt.s2 = q_r.s1;
        if (i_srst) begin
            q_nxt = '0;
        end
    end

    // Register
    always_ff @(posedge i_clock) begin
        q_r <= q_nxt;
    end

    assign o_sync = q_r.s2;

endmodule : asc_sync

`default_nettype wire

// ===== hw/asc_link.sv
// Purpose: link-clock logic: counts falling shift edges, collects input bits
// Assumes: host changes data_in away from the falling edge
// Notes: count leaves gray coded; hist is stable between edges
`default_nettype none

module asc_link (
    // Link clock and core reset level
    input wire logic i_link_clock,
    input wire logic i_srst,
    // Serial input bit
    input wire logic i_data_in,
    // Towards the core
    output logic [2:0] o_gray,
    output logic [7:0] o_hist
);
    import asc_pkg::*;

    asc_link_type q_r;   // Link state
    asc_link_type q_nxt; // Next link state
    logic [2:0] bin_inc; // Incremented count

    // =================================================================
    // Next value: reset is a level brought over in two stages
    always_comb begin
        bin_inc = q_r.bin + 3'h1;
        q_nxt = q_r;
        q_nxt.r1 = i_srst;
        q_nxt.r2 = q_r.r1;
        if (q_r.r2) begin
            // Held in reset
            q_nxt.bin = '0;
            q_nxt.gray = '0;
            q_nxt.hist = '0;
        end else begin
            // One step per falling edge
            q_nxt.bin = bin_inc;
            q_nxt.gray = bin_inc ^ (bin_inc >> 1);
            q_nxt.hist = {q_r.hist[6:0], i_data_in};
        end
    end

    // Register on the falling edge
    always_ff @(negedge i_link_clock) begin
        q_r <= q_nxt;
    end

    assign o_gray = q_r.gray;
    assign o_hist = q_r.hist;

endmodule : asc_link

`default_nettype wire

// ===== verif/asc_host_model.sv
// Purpose: host serial port model driving select, shift clock and address bits
// Assumes: shift clock stands low outside frames
// Notes: each bit slot is stretched so the core sees every edge
`default_nettype none

module asc_host_model (
    // Core clock for pin updates
    input wire logic i_clock,
    // Device result pin
    input wire logic i_data_out,
    // Host pins
    output logic o_link_clock,
    output logic o_cs_n,
    output logic o_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==============================================================
    // State seen by the bench
    event ev_addr; // Fourth falling edge passed
    event ev_word; // Whole word shifted out
    logic [15:0] rx_word; // Bits read back
    initial begin
        o_link_clock = 1'b0;
        o_cs_n = 1'b1;
        o_data_in = 1'b0;
    end
    // Bare shift clock pulses, no data
    task automatic pulse(input int n);
        repeat (n) begin
            #62.5 o_link_clock = 1'b1;
            #62.5 o_link_clock = 1'b0;
            #400;
        end
    endtask : pulse
    // Select change, then the settle time before clocking
    task automatic select(input logic cs_n);
        @(posedge i_clock);
        o_cs_n <= cs_n;
        #2000;
    endtask : select
    // One cycle of exactly 16 edges, power-down too
    task automatic frame(input logic [7:0] ctl);
        for (int k = 0; k < 16; k++) begin
            @(posedge i_clock);
            o_data_in <= (k < 8) ? ctl[7 - k] : 1'b0;
            #13 o_link_clock = 1'b1;
            #50 rx_word[15 - k] = i_data_out;
            #12.5 o_link_clock = 1'b0;
            if (k == 3) -> ev_addr;
            #400;
        end
        -> ev_word;
    endtask : frame
endmodule : asc_host_model

`default_nettype wire

// ===== verif/asc_ctrl_monitor.sv
// Purpose: port-level checks of the converter control
// Assumes: bound to the top control module
// Notes: one core clock domain only
`default_nettype none

module asc_ctrl_monitor #(
    parameter int CS_DEB_CYCLES = 29,
    parameter int STEP_CYCLES = 16
) (
    // Core clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Serial link
    input wire logic i_link_clock,
    input wire asc_pkg::asc_ser_in_type i_ser,
    input wire asc_pkg::asc_ser_out_type o_ser,
    // Analog array side
    input wire logic i_cmp_above,
    input wire logic [11:0] o_trial,
    input wire logic o_sample,
    input wire asc_pkg::asc_mux_type o_mux,
    input wire logic o_power_down
);
    import asc_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // ==============================================================
    // Helper counters
    logic [9:0] low_r; // Cycles with done low
    logic hi_r; // Select rose during conversion
    logic [9:0] cs_hi_r; // Cycles with select high
    always_ff @(posedge i_clock) begin
        if (i_srst || o_ser.eoc) begin
            low_r <= '0;
            hi_r <= 1'b0;
        end else begin
            low_r <= low_r + 10'h001;
            hi_r <= hi_r | i_ser.cs_n;
        end
        cs_hi_r <= (i_srst || !i_ser.cs_n) ? '0 : cs_hi_r + 10'(cs_hi_r != 10'h3FF);
    end
    // ==============================================================
    // Properties
    AST_FLOAT: assert property (i_ser.cs_n |-> o_ser.data_oe_n)
        else $error("result line driven while deselected");
    AST_RESET: assert property (disable iff (1'b0)
        i_srst |=> o_ser.eoc && o_power_down && !o_sample)
        else $error("bad reset state");
    AST_DESEL: assert property (cs_hi_r > 10'(CS_DEB_CYCLES + 4)
        |-> o_ser.eoc && !o_sample && $stable(o_power_down))
        else $error("activity while deselected");
    AST_CONV_LEN: assert property ($rose(o_ser.eoc) && !hi_r
        |-> low_r == 10'(12 * STEP_CYCLES))
        else $error("conversion length wrong");
    AST_MSB_TRIAL: assert property ($fell(o_ser.eoc) |-> o_trial == 12'h800)
        else $error("first trial not msb");
    AST_HOLD: assert property ($fell(o_ser.eoc) |-> $past(o_sample) && !o_sample)
        else $error("sample not held at conversion start");
    AST_WAKE: assert property ($fell(o_ser.eoc) |-> ##[0:2] !o_power_down)
        else $error("conversion while powered down");
    AST_BBM: assert property ($changed(o_mux) && o_mux != '0
        |-> $past(o_mux) == '0)
        else $error("mux made before break");
    AST_DOUT_LOW: assert property (!o_ser.eoc |-> !o_ser.data_out)
        else $error("data out not zero in conversion");
endmodule : asc_ctrl_monitor

bind asc_ctrl asc_ctrl_monitor #(.CS_DEB_CYCLES(CS_DEB_CYCLES), .STEP_CYCLES(STEP_CYCLES))
    u_mon (.i_clock(i_clock), .i_srst(i_srst), .i_link_clock(i_link_clock), .i_ser(i_ser),
    .o_ser(o_ser), .i_cmp_above(i_cmp_above), .o_trial(o_trial), .o_sample(o_sample),
    .o_mux(o_mux), .o_power_down(o_power_down));

`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench of the converter control
// Assumes: counts shortened through parameters
// Notes: comparator is modelled from a target code
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import asc_pkg::*;
    // ==============================================================
    // Signals
    logic clock; // Unknown at start, taken as low
    logic srst; // Raised at time zero by the sequence
    logic cmp_above; // Comparator model output
    logic link_clock, cs_n, din;
    asc_ser_in_type ser;
    asc_ser_out_type ser_o;
    logic [11:0] trial;
    logic sample, pd;
    asc_mux_type mux;
    logic [11:0] target = '0; // Analog input as a code
    logic [11:0] last_res = '0; // Last completed result
    logic prev_pd = 1'b1; // Power-down after reset
    logic prev_lsbf = 1'b0; // Output order of the running cycle
    logic [31:0] seed = 32'h8AFD;
    int bad_count = 0;
    int n_compared = 0;
    logic [16:0] word_q[$]; // Check flag and word
    asc_mux_type mux_q[$];
    logic [1:0] flag_q[$]; // Power-down and sample
    assign ser = {cs_n, din};
    always #25 clock = (clock !== 1'b1);
    // Ideal comparator: above trip when trial exceeds input
    always @(posedge clock) cmp_above <= (trial > target);
    asc_ctrl #(.CS_DEB_CYCLES(3), .IDLE_CYCLES(2), .STEP_CYCLES(2)) DUT (
        .i_clock(clock), .i_srst(srst), .i_link_clock(link_clock), .i_ser(ser),
        .o_ser(ser_o), .i_cmp_above(cmp_above), .o_trial(trial), .o_sample(sample),
        .o_mux(mux), .o_power_down(pd));
    asc_host_model host (.i_clock(clock), .i_data_out(ser_o.data_out),
        .o_link_clock(link_clock), .o_cs_n(cs_n), .o_data_in(din));
    // ==============================================================
    // Compare tasks
    task automatic note(input logic ok, input string msg);
        n_compared++;
        if (!ok) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : note
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        note(got === exp, $sformatf("word %h not %h", got, exp));
    endtask : cmp_word
    task automatic cmp_mux(input asc_mux_type got, input asc_mux_type exp);
        note(got === exp, $sformatf("mux %h not %h", got, exp));
    endtask : cmp_mux
    task automatic cmp_flag(input logic got, input logic exp);
        note(got === exp, $sformatf("flag %b not %b", got, exp));
    endtask : cmp_flag
    // Expected mux setting of an address
    function automatic asc_mux_type exp_mux(input logic [3:0] a);
        exp_mux = '0;
        if (a inside {4'hB, 4'hC, 4'hD}) begin
            exp_mux.test_en = 1'b1;
            exp_mux.test_sel = 2'(a - 4'hB);
        end else if (a != 4'hE) begin
            exp_mux.ext_en = 1'b1;
            exp_mux.ext_ch = a;
        end
    endfunction : exp_mux
    function automatic logic [11:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[11:0];
    endfunction : rnd
    // ==============================================================
    // Result watchers
    always @(host.ev_word) begin
        if (word_q[0][16]) cmp_word(host.rx_word, word_q[0][15:0]);
        void'(word_q.pop_front());
    end
    always @(host.ev_addr) begin
        #400;
        cmp_mux(mux, mux_q.pop_front());
        cmp_flag(pd, flag_q[0][1]);
        cmp_flag(sample, flag_q[0][0]);
        void'(flag_q.pop_front());
    end
    // ==============================================================
    // Driver: one 16-bit cycle with control nibble c, then wait for done
    task automatic run(input logic [3:0] a, input logic [11:0] tgt, input logic chk,
                       input logic abort, input logic [3:0] c);
        logic [15:0] w;
        logic [15:0] r;
        w = {last_res, 4'h0};
        for (int i = 0; i < 16; i++) r[i] = w[15 - i];
        word_q.push_back({chk, prev_lsbf ? r : w});
        mux_q.push_back(exp_mux(a));
        flag_q.push_back({(a == 4'hE) || prev_pd, a != 4'hE});
        target = tgt;
        host.frame({a, c});
        prev_pd = (a == 4'hE);
        prev_lsbf = c[1];
        if (abort) begin
            host.select(1'b1);
            cmp_flag(ser_o.data_oe_n, 1'b1);
            cmp_flag(ser_o.eoc, 1'b1);
            host.pulse(3);
            host.select(1'b0);
        end else if (a != 4'hE) begin
            last_res = {tgt[11] ^ c[0], tgt[10:0]};
        end
        repeat (10) @(posedge clock);
        for (int i = 0; i < 200 && ser_o.eoc !== 1'b1; i++) @(posedge clock);
        cmp_flag(ser_o.eoc, 1'b1);
        repeat (2) @(posedge clock);
    endtask : run
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #2_000_000;
        bad_count++;
        end_sim();
    end
    // ==============================================================
    // Main sequence
    initial begin
        srst <= 1'b1;
        host.pulse(3);
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        cmp_flag(pd, 1'b1);
        cmp_flag(ser_o.data_oe_n, 1'b1);
        // Link reset stages clear only on shift edges; give them while deselected
        host.pulse(3);
        host.select(1'b0);
        run(4'h0, 12'h000, 1'b0, 1'b0, 4'hC);
        // Bipolar on channel 6, LSB-first order after channel 9
        for (int a = 1; a < 16; a++) begin
            run(4'(a), (a == 1) ? 12'hFFF : rnd(), 1'b1, 1'b0,
                (a == 6) ? 4'hD : (a == 9) ? 4'hE : 4'hC);
        end
        run(4'h3, 12'h5A5, 1'b1, 1'b1, 4'hC);
        run(4'h5, rnd(), 1'b1, 1'b0, 4'hC);
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
